//--- hdl/four_port_gpio.v
// Four-port GPIO block with peripheral overrides and AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.vh"

module four_port_gpio (
  input wire aclk,
  input wire aresetn,
  input wire power_on,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_b_in,
  output wire [7:0] port_b_out,
  output wire [7:0] port_b_oe_n,
  output wire [7:0] port_b_pullup,
  input wire [7:0] port_c_in,
  output wire [7:0] port_c_out,
  output wire [7:0] port_c_oe_n,
  input wire [7:0] periph_sel,
  input wire [7:0] periph_oe,
  input wire [7:0] periph_out,
  output wire [7:0] periph_in,
  input wire [7:0] port_d_in,
  output wire [7:0] port_d_out,
  output wire [7:0] port_d_oe_n,
  input wire [2:0] port_e_in,
  output wire [2:0] port_e_out,
  output wire [2:0] port_e_oe_n,
  output wire [2:0] analog_select,
  output wire ext_irq_pin,
  output wire prog_enable_pin,
  output wire prog_clock_pin,
  output wire prog_data_pin,
  input wire prog_data_out,
  input wire prog_data_drive,
  output wire port_change_flag,
  output wire ext_irq_flag
);

  localparam NSYNC = 27;

  // Pin synchronisers: three stages, accept when stages two and three agree
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  reg [NSYNC-1:0] sync3_reg;
  reg [NSYNC-1:0] pins_reg;
  wire [NSYNC-1:0] raw_pins;
  wire [NSYNC-1:0] agree;

  assign raw_pins = {port_e_in, port_d_in, port_c_in, port_b_in};
  assign agree = ~(sync2_reg ^ sync3_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= {NSYNC{1'b0}};
      sync2_reg <= {NSYNC{1'b0}};
      sync3_reg <= {NSYNC{1'b0}};
      pins_reg <= {NSYNC{1'b0}};
    end else begin
      sync1_reg <= raw_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg <= (sync2_reg & agree) | (pins_reg & ~agree);
    end
  end

  wire [7:0] pb = pins_reg[7:0];
  wire [7:0] pc = pins_reg[15:8];
  wire [7:0] pd = pins_reg[23:16];
  wire [2:0] pe = pins_reg[26:24];

  // Registers
  reg [7:0] latch_b_reg;
  reg [7:0] latch_c_reg;
  reg [7:0] latch_d_reg;
  reg [2:0] latch_e_reg;
  reg [7:0] option_ctrl_reg;
  reg [7:0] dir_b_reg;
  reg [7:0] dir_c_reg;
  reg [7:0] dir_d_reg;
  reg [7:0] dir_e_reg;
  reg [7:0] analog_cfg_reg;
  reg [1:0] irq_reg;
  reg [1:0] special_reg;
  reg [3:0] change_old_reg;
  reg ext_prev_reg;
  reg [7:0] slave_in_reg;
  reg wr_act_prev_reg;
  reg rd_act_prev_reg;
  reg [4:0] settle_reg;

  // AXI4-Lite slave state
  reg aw_held_reg;
  reg w_held_reg;
  reg [9:0] waddr_reg;
  reg [7:0] wdata_reg;
  reg wstrb_reg;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire do_read = s_axi_arvalid & ~s_axi_rvalid;
  wire [9:0] raddr = s_axi_araddr[11:2];
  wire wr_en = do_write & wstrb_reg;

  function hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      hit = (addr == {2'b00, idx});
    end
  endfunction

  wire wr_b = wr_en & hit(waddr_reg, `IDX_PORT_B_PINS);
  wire wr_c = wr_en & hit(waddr_reg, `IDX_PORT_C_PINS);
  wire wr_d = wr_en & hit(waddr_reg, `IDX_PORT_D_PINS);
  wire wr_e = wr_en & hit(waddr_reg, `IDX_PORT_E_PINS);
  wire wr_opt = wr_en & hit(waddr_reg, `IDX_OPTION_CONTROL);
  wire wr_dir_b = wr_en & hit(waddr_reg, `IDX_PORT_B_DIRECTION);
  wire wr_dir_c = wr_en & hit(waddr_reg, `IDX_PORT_C_DIRECTION);
  wire wr_dir_d = wr_en & hit(waddr_reg, `IDX_PORT_D_DIRECTION);
  wire wr_dir_e = wr_en & hit(waddr_reg, `IDX_PORT_E_DIR_STATUS);
  wire wr_analog = wr_en & hit(waddr_reg, `IDX_ANALOG_CONFIG);
  wire wr_irq = wr_en & hit(waddr_reg, `IDX_IRQ_CONTROL);
  wire wr_spc = wr_en & hit(waddr_reg, `IDX_SPECIAL_CONTROL);
  wire rd_b = do_read & hit(raddr, `IDX_PORT_B_PINS);
  wire rd_d = do_read & hit(raddr, `IDX_PORT_D_PINS);

  wire slave_mode = dir_e_reg[`PE_SLAVE_MODE];
  wire low_volt = special_reg[`SPC_LOW_VOLT];
  wire debug = special_reg[`SPC_DEBUG];

  // Analog unless the configuration selects digital on port E
  wire e_digital = (analog_cfg_reg[3:1] == 3'b011);
  assign analog_select = {3{~e_digital}};

  // Slave port strobes; pins are E0 read, E1 write, E2 select, active low
  wire wr_act = slave_mode & ~pe[2] & ~pe[1];
  wire rd_act = slave_mode & ~pe[2] & ~pe[0];
  wire wr_done = wr_act_prev_reg & ~wr_act;
  wire rd_start = rd_act & ~rd_act_prev_reg;

  // Change detection on inputs among bits 7..4
  wire [3:0] mismatch = (pb[7:4] ^ change_old_reg) & dir_b_reg[7:4];
  wire change_set = |mismatch;

  // External interrupt edge on bit 0, muted while the pipeline refills
  wire ext_edge = settle_reg[4] & (option_ctrl_reg[`OPT_EXT_EDGE] ?
                  (pb[0] & ~ext_prev_reg) : (~pb[0] & ext_prev_reg));

  wire wmapped = hit(waddr_reg, `IDX_PORT_B_PINS) |
                 hit(waddr_reg, `IDX_PORT_C_PINS) |
                 hit(waddr_reg, `IDX_PORT_D_PINS) |
                 hit(waddr_reg, `IDX_PORT_E_PINS) |
                 hit(waddr_reg, `IDX_OPTION_CONTROL) |
                 hit(waddr_reg, `IDX_PORT_B_DIRECTION) |
                 hit(waddr_reg, `IDX_PORT_C_DIRECTION) |
                 hit(waddr_reg, `IDX_PORT_D_DIRECTION) |
                 hit(waddr_reg, `IDX_PORT_E_DIR_STATUS) |
                 hit(waddr_reg, `IDX_ANALOG_CONFIG) |
                 hit(waddr_reg, `IDX_IRQ_CONTROL) |
                 hit(waddr_reg, `IDX_SPECIAL_CONTROL);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 10'h000;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux
  reg [7:0] rd_value;
  reg rd_mapped;

  always @* begin
    rd_value = 8'h00;
    rd_mapped = 1'b1;
    case (raddr)
      {2'b00, `IDX_PORT_B_PINS}: rd_value = pb;
      {2'b00, `IDX_PORT_C_PINS}: rd_value = pc;
      {2'b00, `IDX_PORT_D_PINS}: rd_value = slave_mode ? slave_in_reg : pd;
      {2'b00, `IDX_PORT_E_PINS}: rd_value = {5'h00, pe & {3{e_digital}}};
      {2'b00, `IDX_OPTION_CONTROL}: rd_value = option_ctrl_reg;
      {2'b00, `IDX_PORT_B_DIRECTION}: rd_value = dir_b_reg;
      {2'b00, `IDX_PORT_C_DIRECTION}: rd_value = dir_c_reg;
      {2'b00, `IDX_PORT_D_DIRECTION}: rd_value = dir_d_reg;
      {2'b00, `IDX_PORT_E_DIR_STATUS}: rd_value = dir_e_reg;
      {2'b00, `IDX_ANALOG_CONFIG}: rd_value = analog_cfg_reg & 8'h8f;
      {2'b00, `IDX_IRQ_CONTROL}: rd_value = {6'h00, irq_reg};
      {2'b00, `IDX_SPECIAL_CONTROL}: rd_value = {6'h00, special_reg};
      default: rd_mapped = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_value};
      s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control and data registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      dir_b_reg <= `RST_DIRECTION;
      dir_c_reg <= `RST_DIRECTION;
      dir_d_reg <= `RST_DIRECTION;
      dir_e_reg <= `RST_PORT_E_DIR;
      option_ctrl_reg <= `RST_OPTION;
      irq_reg <= 2'b00;
      ext_prev_reg <= 1'b0;
      wr_act_prev_reg <= 1'b0;
      rd_act_prev_reg <= 1'b0;
      settle_reg <= 5'h00;
      // Latches only cleared by power-on; other resets keep them
      if (power_on) begin
        latch_b_reg <= `RST_LATCH;
        latch_c_reg <= `RST_LATCH;
        latch_d_reg <= `RST_LATCH;
        latch_e_reg <= 3'b000;
        change_old_reg <= 4'h0;
        slave_in_reg <= `RST_LATCH;
        analog_cfg_reg <= `RST_ANALOG_CONFIG;
        special_reg <= 2'b00;
      end
    end else begin
      ext_prev_reg <= pb[0];
      wr_act_prev_reg <= wr_act;
      rd_act_prev_reg <= rd_act;
      settle_reg <= {settle_reg[3:0], 1'b1};
      if (wr_b)
        latch_b_reg <= wdata_reg;
      if (wr_c)
        latch_c_reg <= wdata_reg;
      if (wr_d)
        latch_d_reg <= wdata_reg;
      if (wr_e)
        latch_e_reg <= wdata_reg[2:0];
      if (wr_opt)
        option_ctrl_reg <= wdata_reg;
      if (wr_dir_b)
        dir_b_reg <= wdata_reg;
      if (wr_dir_c)
        dir_c_reg <= wdata_reg;
      if (wr_dir_d)
        dir_d_reg <= wdata_reg;
      if (wr_analog)
        analog_cfg_reg <= wdata_reg & 8'h8f;
      if (wr_spc)
        special_reg <= wdata_reg[1:0];
      // Any port B read or write re-arms the comparison
      if (rd_b || wr_b)
        change_old_reg <= pb[7:4];
      // Flags: written zero clears, hardware set wins
      irq_reg[`IRQ_CHANGE] <= change_set |
        (irq_reg[`IRQ_CHANGE] & ~(wr_irq & ~wdata_reg[`IRQ_CHANGE]));
      irq_reg[`IRQ_EXT] <= ext_edge |
        (irq_reg[`IRQ_EXT] & ~(wr_irq & ~wdata_reg[`IRQ_EXT]));
      if (wr_done)
        slave_in_reg <= pd;
      // Port E status and control
      if (wr_dir_e) begin
        dir_e_reg[`PE_SLAVE_MODE] <= wdata_reg[`PE_SLAVE_MODE];
        dir_e_reg[2:0] <= wdata_reg[2:0];
      end
      dir_e_reg[3] <= 1'b0;
      if (!slave_mode) begin
        dir_e_reg[`PE_IN_FULL] <= 1'b0;
        dir_e_reg[`PE_OUT_FULL] <= 1'b0;
      end else begin
        dir_e_reg[`PE_IN_FULL] <= wr_done |
          (dir_e_reg[`PE_IN_FULL] & ~rd_d);
        dir_e_reg[`PE_OUT_FULL] <= wr_d |
          (dir_e_reg[`PE_OUT_FULL] & ~rd_start);
      end
      // Overrun sticks until software writes zero
      dir_e_reg[`PE_IN_OVERRUN] <= (wr_done & dir_e_reg[`PE_IN_FULL]) |
        (dir_e_reg[`PE_IN_OVERRUN] &
         ~(wr_dir_e & ~wdata_reg[`PE_IN_OVERRUN]));
    end
  end

  // Port B pins
  wire [7:0] b_drive;
  wire [7:0] b_value;
  // Bit 3 is handed to programming when low-voltage mode is on
  assign b_drive = ~dir_b_reg & ~{debug, debug, 2'b00, low_volt, 3'b000} |
                   {debug & prog_data_drive, 7'h00};
  assign b_value = {debug ? prog_data_out : latch_b_reg[7],
                    latch_b_reg[6:0]};
  assign port_b_out = b_value;
  assign port_b_oe_n = ~b_drive;
  // Pull-ups: global enable, only on pins not driven
  assign port_b_pullup = {8{~option_ctrl_reg[`OPT_PULLUP_DISABLE_N]}} &
                         ~b_drive;
  assign ext_irq_pin = pb[0];
  assign prog_enable_pin = low_volt & pb[3];
  assign prog_clock_pin = debug & pb[6];
  assign prog_data_pin = debug & pb[7];
  assign port_change_flag = irq_reg[`IRQ_CHANGE];
  assign ext_irq_flag = irq_reg[`IRQ_EXT];

  // Port C: selected peripheral owns value and direction
  wire [7:0] c_drive = (periph_sel & periph_oe) |
                       (~periph_sel & ~dir_c_reg);
  assign port_c_out = (periph_sel & periph_out) |
                      (~periph_sel & latch_c_reg);
  assign port_c_oe_n = ~c_drive;
  assign periph_in = pc;

  // Port D: in slave mode the host strobes own the direction
  assign port_d_out = latch_d_reg;
  assign port_d_oe_n = slave_mode ? {8{~rd_act}} : dir_d_reg;

  // Port E: direction bits stay in charge even in analog use
  assign port_e_out = latch_e_reg;
  assign port_e_oe_n = dir_e_reg[2:0];

endmodule // four_port_gpio
`default_nettype wire

//--- common/gpio_map.vh
// Register indices, field positions and reset values for the port block
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// Register indices; byte address is four times the index
`define IDX_PORT_B_PINS 8'h06
`define IDX_PORT_C_PINS 8'h07
`define IDX_PORT_D_PINS 8'h08
`define IDX_PORT_E_PINS 8'h09
`define IDX_OPTION_CONTROL 8'h81
`define IDX_PORT_B_DIRECTION 8'h86
`define IDX_PORT_C_DIRECTION 8'h87
`define IDX_PORT_D_DIRECTION 8'h88
`define IDX_PORT_E_DIR_STATUS 8'h89
`define IDX_ANALOG_CONFIG 8'h9f
`define IDX_IRQ_CONTROL 8'ha0
`define IDX_SPECIAL_CONTROL 8'ha1

// Reset values
`define RST_DIRECTION 8'hff
`define RST_OPTION 8'hff
`define RST_PORT_E_DIR 8'h07
`define RST_ANALOG_CONFIG 8'h00
`define RST_LATCH 8'h00

// option_control fields
`define OPT_PULLUP_DISABLE_N 7
`define OPT_EXT_EDGE 6

// port_e_direction_slave_status fields
`define PE_IN_FULL 7
`define PE_OUT_FULL 6
`define PE_IN_OVERRUN 5
`define PE_SLAVE_MODE 4
`define PE_WRITABLE 8'h37

// irq_control fields
`define IRQ_CHANGE 0
`define IRQ_EXT 1

// special_control fields
`define SPC_LOW_VOLT 0
`define SPC_DEBUG 1

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- verif/pin_pad_model.sv
// Pad model: resolves each pin from the block, the outside world and pulls
`timescale 1ns/100ps
`default_nettype none
module pin_pad_model #(parameter int W = 8) (
  input wire logic clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] ext,
  input wire logic ext_on,
  output logic [W-1:0] level
);
  logic [W-1:0] pat = '0;
  // Floating pads wander so a stale value never passes
  always @(posedge clk) pat <= ~pat;
  always_comb
    for (int i = 0; i < W; i++)
      level[i] = !oe_n[i] ? out[i] :
        ext_on ? ext[i] : pull[i] ? 1'b1 : pat[i];
endmodule // pin_pad_model
`default_nettype wire

//--- verif/four_port_gpio_chk.sv
// Bus and pin checks for the port block
`timescale 1ns/100ps
`default_nettype none
module four_port_gpio_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_b_in,
  input wire [7:0] port_b_oe_n,
  input wire [7:0] port_b_pullup,
  input wire [7:0] port_c_out,
  input wire [7:0] port_c_oe_n,
  input wire [7:0] periph_sel,
  input wire [7:0] periph_oe,
  input wire [7:0] periph_out,
  input wire [7:0] port_d_oe_n,
  input wire [2:0] port_e_oe_n,
  input wire ext_irq_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_time_a: assert property (wr_taken |=> wr_answer)
    else $error("write answer out of time");
  read_time_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer out of time");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  busy_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  pullup_out_a: assert property (
    (port_b_pullup & ~port_b_oe_n) == 8'h0) else $error("pull-up on output");
  periph_dir_a: assert property (
    (periph_sel & (port_c_oe_n ^ ~periph_oe)) == 8'h0)
    else $error("peripheral direction ignored");
  periph_val_a: assert property (
    (periph_sel & periph_oe & (port_c_out ^ periph_out)) == 8'h0)
    else $error("peripheral value not on pin");
  reset_dir_a: assert property ($rose(aresetn) |->
    port_b_oe_n == 8'hff && port_d_oe_n == 8'hff && port_e_oe_n == 3'h7)
    else $error("pins driven after reset");
  ext_irq_a: assert property ($stable(port_b_in[0]) [*5] |->
    ext_irq_pin == port_b_in[0]) else $error("irq pin not following");
endmodule // four_port_gpio_chk
bind four_port_gpio four_port_gpio_chk chk_u (.*);
`default_nettype wire

//--- verif/four_port_gpio_with_overrides_test.sv
// Self-checking bench for the four-port GPIO block
`timescale 1ns/100ps
`default_nettype none
module four_port_gpio_with_overrides_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic power_on = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, b_on = 1'b1;
  logic prog_data_out = 1'b0, prog_data_drive = 1'b0;
  logic far_on = 1'b1;
  logic [7:0] periph_sel = 8'h0, periph_oe = 8'h0, periph_out = 8'h0;
  logic [7:0] ext_b = 8'h0, ext_c = 8'h0, ext_d = 8'h0;
  logic [7:0] dir, lat, ce, co, v;
  logic [2:0] ext_e = 3'h7;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, ext_irq_pin, prog_enable_pin, prog_clock_pin;
  wire prog_data_pin, port_change_flag, ext_irq_flag;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_b_in, port_b_out, port_b_oe_n, port_b_pullup;
  wire [7:0] port_c_in, port_c_out, port_c_oe_n, periph_in;
  wire [7:0] port_d_in, port_d_out, port_d_oe_n;
  wire [2:0] port_e_in, port_e_out, port_e_oe_n, analog_select;
  int error_cnt = 0;
  int n_tests = 0;

  four_port_gpio dut_u (.*);
  pin_pad_model #(.W(8)) pb_u (.clk(aclk), .out(port_b_out),
    .oe_n(port_b_oe_n), .pull(port_b_pullup), .ext(ext_b),
    .ext_on(b_on), .level(port_b_in));
  pin_pad_model #(.W(8)) pc_u (.clk(aclk), .out(port_c_out),
    .oe_n(port_c_oe_n), .pull(8'h0), .ext(ext_c), .ext_on(far_on),
    .level(port_c_in));
  pin_pad_model #(.W(8)) pd_u (.clk(aclk), .out(port_d_out),
    .oe_n(port_d_oe_n), .pull(8'h0), .ext(ext_d), .ext_on(far_on),
    .level(port_d_in));
  pin_pad_model #(.W(3)) pe_u (.clk(aclk), .out(port_e_out),
    .oe_n(port_e_oe_n), .pull(3'h0), .ext(ext_e), .ext_on(far_on),
    .level(port_e_in));

  always #5 aclk = ~aclk;

  function automatic logic [7:0] mux(input logic [7:0] s, a, b);
    return (s & a) | (~s & b);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string what, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", what, e, g);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] idx, d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {6'h0, er}, {6'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] idx, ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata[7:0]);
    chk("rresp", {6'h0, er}, {6'h0, s_axi_rresp});
  endtask

  task automatic reg_defaults;
    logic [7:0] idx [5] = '{8'h81, 8'h86, 8'h87, 8'h88, 8'h89};
    logic [7:0] val [5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h07};
    for (int i = 0; i < 5; i++) rd(idx[i], val[i], 2'h0);
  endtask

  task automatic do_reset(input logic por);
    power_on <= por;
    aresetn <= 1'b0;
    cyc(6);
    aresetn <= 1'b1;
  endtask

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(32'hc9b71385));
    do_reset(1'b1);
    chk("analog_sel", 8'h07, {5'h0, analog_select});
    cyc(5);
    rd(8'h09, 8'h00, 2'h0);
    // Byte lane zero off: the write must be dropped
    s_axi_wstrb <= 4'he;
    wr(8'h86, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hf;
    reg_defaults();
    rd(8'h00, 8'h00, 2'h2);
    wr(8'h00, 8'h55, 2'h2);
    $display("test reset and map done");
    wr(8'h81, 8'h7f, 2'h0);
    for (int k = 0; k < 12; k++) begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      periph_sel <= 8'($urandom);
      periph_oe <= 8'($urandom);
      periph_out <= 8'($urandom);
      {ext_b, ext_c, ext_d} <= 24'($urandom);
      b_on <= k[0];
      wr(8'h86, dir, 2'h0);
      wr(8'h06, lat, 2'h0);
      wr(8'h87, dir, 2'h0);
      wr(8'h07, lat, 2'h0);
      wr(8'h88, ~dir, 2'h0);
      wr(8'h08, lat, 2'h0);
      cyc(5);
      ce = mux(periph_sel, ~periph_oe, dir);
      co = mux(periph_sel, periph_out, lat);
      chk("c_oe_n", ce, port_c_oe_n);
      chk("c_out", ~ce & co, ~ce & port_c_out);
      chk("periph_in", mux(~ce, co, ext_c), periph_in);
      chk("b_pullup", dir, port_b_pullup);
      chk("d_oe_n", ~dir, port_d_oe_n);
      chk("d_out", dir & lat, dir & port_d_out);
      rd(8'h06, mux(~dir, lat, b_on ? ext_b : 8'hff), 2'h0);
      rd(8'h08, mux(dir, lat, ext_d), 2'h0);
    end
    $display("test random ports done");
    // Upper two pins as outputs must stay out of the compare
    wr(8'h86, 8'h3f, 2'h0);
    ext_b <= 8'h00;
    cyc(5);
    rd(8'h06, mux(8'hc0, lat, 8'h00), 2'h0);
    wr(8'ha0, 8'h00, 2'h0);
    ext_b <= 8'hcf;
    cyc(6);
    chk("chg_low", 8'h0, {7'h0, port_change_flag});
    ext_b <= 8'hef;
    cyc(6);
    chk("chg_high", 8'h1, {7'h0, port_change_flag});
    rd(8'h06, mux(8'hc0, lat, 8'hef), 2'h0);
    wr(8'ha0, 8'h00, 2'h0);
    chk("chg_clear", 8'h0, {7'h0, port_change_flag});
    v = 8'($urandom);
    ext_b <= v;
    wr(8'ha1, 8'h03, 2'h0);
    cyc(5);
    chk("prog_pins", {5'h0, v[7], v[6], v[3]},
      {5'h0, prog_data_pin, prog_clock_pin, prog_enable_pin});
    chk("ext_irq", {7'h0, v[0]}, {7'h0, ext_irq_pin});
    prog_data_out <= v[2];
    prog_data_drive <= 1'b1;
    cyc(5);
    chk("prog_drive", {v[2], v[2], 2'b01, 4'h0},
      {port_b_out[7], prog_data_pin, port_b_oe_n[7:6], 4'h0});
    prog_data_drive <= 1'b0;
    wr(8'ha1, 8'h00, 2'h0);
    cyc(5);
    chk("prog_off", 8'h0,
      {5'h0, prog_data_pin, prog_clock_pin, prog_enable_pin});
    ext_b[0] <= 1'b0;
    cyc(6);
    wr(8'ha0, 8'h00, 2'h0);
    chk("ext_flag_idle", 8'h0, {7'h0, ext_irq_flag});
    ext_b[0] <= 1'b1;
    cyc(6);
    chk("ext_flag", 8'h1, {7'h0, ext_irq_flag});
    $display("test port b functions done");
    wr(8'h9f, 8'h06, 2'h0);
    ext_e <= 3'h5;
    cyc(5);
    chk("analog_sel", 8'h0, {5'h0, analog_select});
    rd(8'h09, 8'h05, 2'h0);
    wr(8'h09, 8'h05, 2'h0);
    chk("e_out", 8'h05, {5'h0, port_e_out});
    wr(8'h89, 8'h02, 2'h0);
    chk("e_oe_n", 8'h02, {5'h0, port_e_oe_n});
    ext_e <= 3'h7;
    wr(8'h89, 8'h17, 2'h0);
    wr(8'h08, 8'ha5, 2'h0);
    ext_d <= v;
    ext_e <= 3'h1;
    cyc(6);
    ext_e <= 3'h7;
    cyc(6);
    rd(8'h89, 8'hd7, 2'h0);
    rd(8'h08, v, 2'h0);
    rd(8'h89, 8'h57, 2'h0);
    ext_e <= 3'h2;
    cyc(6);
    chk("d_slave_oe", 8'h0, port_d_oe_n);
    chk("d_slave_out", 8'ha5, port_d_out);
    ext_e <= 3'h7;
    cyc(6);
    rd(8'h89, 8'h17, 2'h0);
    // Two host writes with no read in between must flag an overrun
    repeat (2) begin
      ext_e <= 3'h1;
      cyc(6);
      ext_e <= 3'h7;
      cyc(6);
    end
    rd(8'h89, 8'hb7, 2'h0);
    wr(8'h89, 8'h17, 2'h0);
    rd(8'h89, 8'h97, 2'h0);
    $display("test slave port done");
    do_reset(1'b0);
    reg_defaults();
    wr(8'h88, 8'h00, 2'h0);
    chk("d_kept", 8'ha5, port_d_out);
    chk("analog_kept", 8'h0, {5'h0, analog_select});
    chk("ext_flag_reset", 8'h0, {7'h0, ext_irq_flag});
    // Outside world lets go: driven D pins must read back the latch
    far_on <= 1'b0;
    cyc(5);
    rd(8'h08, 8'ha5, 2'h0);
    $display("test warm reset done");
    test_done();
  end
endmodule // four_port_gpio_with_overrides_test
`default_nettype wire
